/* rtl/flash_access_map.svh */
`ifndef FLASH_ACCESS_MAP_SVH
`define FLASH_ACCESS_MAP_SVH

// Byte offsets on the register bus; bit 15 of the address opens the window
`define OFS_FLASH_CONTROL  16'h0000
`define OFS_UNLOCK_KEY     16'h0004
`define OFS_TABLE_PAGE     16'h0008
`define OFS_VIS_PAGE       16'h000c
`define OFS_CORE_CONTROL   16'h0010
`define OFS_TABLE_ADDR     16'h0014
`define OFS_TABLE_DATA     16'h0018
`define OFS_TABLE_CMD      16'h001c
`define OFS_WINDOW_TIMING  16'h0020

// Field positions
`define FC_WR_BIT          15
`define FC_WEN_BIT         14
`define FC_ERR_BIT         13
`define FC_ERASE_BIT       6
`define CC_WINDOW_BIT      2
`define WT_MOVE_BIT        0
`define WT_REPEAT_BIT      1
`define WT_EDGE_BIT        2
`define TC_HIGH_BIT        0
`define TC_WRITE_BIT       1
`define TC_BYTE_BIT        2

// Values
`define KEY_FIRST          8'h55
`define KEY_SECOND         8'haa
`define OP_ROW             4'h1
`define OP_PAGE            4'h2
`define OP_WORD            4'h3
`define ERASED_WORD        24'hffffff
`define CONFIG_READ_WORD   24'hffffff
`define ROW_WORDS          10'h040
`define PAGE_WORDS         10'h200

// Timing, in fast RC oscillator cycles
`define ROW_WRITE_OSC      11064
`define PAGE_ERASE_OSC     11064
`define WORD_WRITE_OSC     200

`endif

/* rtl/flash_access_pkg.sv */
`default_nettype none
package flash_access_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RD1  = 3'b001,
    ST_RD2  = 3'b010,
    ST_PEN  = 3'b011,
    ST_RESP = 3'b100,
    ST_OP   = 3'b101
  } bus_state_t;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_HALF = 2'b01,
    KEY_OPEN = 2'b10
  } key_state_t;

endpackage : flash_access_pkg
`default_nettype wire

/* rtl/program_store.sv */
`timescale 1ns/1ps
`default_nettype none

module program_store #(
  parameter int AW    = 6,
  parameter int LANES = 3
) (
  input  wire logic                 mclk,    // system clock
  input  wire logic [LANES-1:0]     we_lane, // byte lane write enables
  input  wire logic [AW-1:0]        waddr,   // write word index
  input  wire logic [LANES*8-1:0]   wdata,   // write word
  input  wire logic [AW-1:0]        raddr,   // read word index
  output logic      [LANES*8-1:0]   rdata    // registered read word
);

  // One array per lane, so each array has a single writer
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [7:0] mem [0:(1<<AW)-1];
      always_ff @(posedge mclk) begin
        if (we_lane[g]) begin
          mem[waddr] <= wdata[g*8 +: 8];
        end
        rdata[g*8 +: 8] <= mem[raddr];
      end
    end
  endgenerate

endmodule : program_store

`default_nettype wire

/* rtl/program_space_access.sv */
// Operation
// - Low table ops reach program word bits 15..0, word or byte size.
// - High table ops reach program word bits 23..16, word or byte size.
// - Low byte read picks upper byte when byte select is 1, else lower.
// - High word read returns bits 23..16 with upper result byte zero.
// - High byte read returns zero for byte select 1, else bits 23..16.
// - Table address is page register above 16-bit effective address.
// - Page bit 7 clear targets user memory, set targets configuration space.
// - Two address units per program word; data and program addresses align.
// - Window mapping only when address bit 15 and enable bit 2 set.
// - Window address is visibility page above lower 15 address bits.
// - Window reads return low 16 bits only, read-only, extra fetch cycle.
// - Window mapping suspended while a table operation is in progress.
// - Outside repeat, moves add one cycle, other instructions add two.
// - In repeat, edge iterations add two cycles, others add none.
// - Rows of 64 words, erase pages of eight rows, naturally aligned.
// - Self-programming erases a page, programs a row, or one word.
// - Table writes only fill holding buffers, two cycles each.
// - Processor stalls until a started erase or program finishes.
// - Setting write-start bit begins operation; hardware clears it when done.
// - Erase and program times count fast RC cycles; row takes 11064.
// - Select 0010 erase, 0001 row, 0011 word; mismatches do nothing.
// - Erase and program inhibited unless write-enable bit is set.
// - Improper sequence attempt sets the sequence error flag.
// - Page erase target latched from a dummy low table write.
//
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "flash_access_map.svh"

module program_space_access #(
  parameter int PROG_AW        = 16,               // word index bits of user flash
  parameter int ROW_WRITE_OSC  = `ROW_WRITE_OSC,
  parameter int PAGE_ERASE_OSC = `PAGE_ERASE_OSC,
  parameter int WORD_WRITE_OSC = `WORD_WRITE_OSC
) (
  input  wire logic        mclk,             // 20 MHz system clock
  input  wire logic        reset_n,          // synchronous reset, active low
  input  wire logic [15:0] avs_address,      // byte address
  input  wire logic        avs_read,         // read request
  input  wire logic        avs_write,        // write request
  input  wire logic [31:0] avs_writedata,    // write data
  input  wire logic [3:0]  avs_byteenable,   // byte enables
  output logic      [31:0] avs_readdata,     // read data
  output logic             avs_waitrequest,  // stall, low for one answer cycle
  input  wire logic        osc_clock_in      // fast RC oscillator, asynchronous
);

  flash_access_pkg::bus_state_t state_reg;
  flash_access_pkg::bus_state_t state_next;
  flash_access_pkg::key_state_t key_reg;

  logic               osc_meta_reg;
  logic               osc_sync_reg;
  logic               osc_prev_reg;
  logic               wr_reg;
  logic               wen_reg;
  logic               err_reg;
  logic               erase_reg;
  logic [3:0]         opsel_reg;
  logic [7:0]         table_page_reg;
  logic [7:0]         visibility_page_reg;
  logic [15:0]        core_control_reg;
  logic [15:0]        table_addr_reg;
  logic [15:0]        table_data_reg;
  logic [2:0]         table_cmd_reg;
  logic [2:0]         window_timing_reg;
  logic [PROG_AW-1:0] rd_idx_reg;
  logic               rd_cfg_reg;
  logic               rd_win_reg;
  logic               rd_high_reg;
  logic               rd_byte_reg;
  logic               rd_sel_reg;
  logic [1:0]         pen_reg;
  logic [PROG_AW-1:0] target_idx_reg;
  logic [3:0]         op_kind_reg;
  logic [9:0]         step_reg;
  logic [19:0]        osc_cnt_reg;
  logic [2:0]         buf_we_reg;
  logic [5:0]         buf_widx_reg;
  logic [23:0]        buf_wdata_reg;

  logic               req;
  logic               is_win;
  logic               win_rd;
  logic               tbl_rd;
  logic               tbl_wr;
  logic               fc_wr;
  logic               wr_attempt;
  logic               valid_op;
  logic               op_start;
  logic               op_error;
  logic               osc_tick;
  logic               op_done;
  logic [1:0]         penalty;
  logic [23:0]        tbl_full;
  logic [15:0]        fc_value;
  logic [15:0]        fc_new;
  logic [15:0]        read_mux;
  logic [15:0]        tbl_result;
  logic [23:0]        prog_word;
  logic [23:0]        arr_rdata;
  logic [23:0]        buf_rdata;
  logic [2:0]         arr_we;
  logic [PROG_AW-1:0] arr_waddr;
  logic [23:0]        arr_wdata;
  logic [5:0]         buf_raddr;
  logic [9:0]         op_words;
  logic [19:0]        op_limit;
  logic [PROG_AW-1:0] op_base;
  logic [PROG_AW-1:0] step_idx;

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  be);
    merge16 = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
  endfunction : merge16

  // Decode of the request waiting in idle
  assign req      = (state_reg == flash_access_pkg::ST_IDLE) && (avs_read || avs_write);
  assign is_win   = avs_address[15];
  assign win_rd   = req && avs_read && is_win && core_control_reg[`CC_WINDOW_BIT];
  assign tbl_wr   = req && avs_write && !is_win && (avs_address == `OFS_TABLE_CMD)
                    && avs_byteenable[0] && avs_writedata[`TC_WRITE_BIT];
  assign tbl_rd   = req && avs_write && !is_win && (avs_address == `OFS_TABLE_CMD)
                    && avs_byteenable[0] && !avs_writedata[`TC_WRITE_BIT];
  assign fc_wr    = req && avs_write && !is_win && (avs_address == `OFS_FLASH_CONTROL);
  assign tbl_full = {table_page_reg, table_addr_reg};

  assign fc_value = {wr_reg, wen_reg, err_reg, 6'h00, erase_reg, 2'b00, opsel_reg};
  assign fc_new   = merge16(fc_value, avs_writedata[15:0], avs_byteenable[1:0]);

  assign wr_attempt = fc_wr && avs_byteenable[1] && avs_writedata[`FC_WR_BIT];
  assign valid_op   = fc_new[`FC_ERASE_BIT] ? (fc_new[3:0] == `OP_PAGE)
                      : ((fc_new[3:0] == `OP_ROW) || (fc_new[3:0] == `OP_WORD));
  assign op_start   = wr_attempt && (key_reg == flash_access_pkg::KEY_OPEN)
                      && fc_new[`FC_WEN_BIT] && valid_op;
  assign op_error   = wr_attempt && ((key_reg != flash_access_pkg::KEY_OPEN)
                      || !fc_new[`FC_WEN_BIT]);

  // Extra cycles for a window read depend on the instruction context
  assign penalty = (window_timing_reg[`WT_REPEAT_BIT] && !window_timing_reg[`WT_EDGE_BIT]) ? 2'd0 :
                   (window_timing_reg[`WT_EDGE_BIT] || !window_timing_reg[`WT_MOVE_BIT]) ? 2'd2 :
                   2'd1;

  always_ff @(posedge mclk) begin
    osc_meta_reg <= osc_clock_in;
    osc_sync_reg <= osc_meta_reg;
    osc_prev_reg <= osc_sync_reg;
  end
  assign osc_tick = osc_sync_reg && !osc_prev_reg;

  always_comb begin
    case (op_kind_reg)
      `OP_PAGE: begin
        op_words = `PAGE_WORDS;
        op_limit = 20'(PAGE_ERASE_OSC);
        op_base  = {target_idx_reg[PROG_AW-1:9], 9'h000};
      end
      `OP_ROW: begin
        op_words = `ROW_WORDS;
        op_limit = 20'(ROW_WRITE_OSC);
        op_base  = {target_idx_reg[PROG_AW-1:6], 6'h00};
      end
      default: begin
        op_words = 10'h001;
        op_limit = 20'(WORD_WRITE_OSC);
        op_base  = target_idx_reg;
      end
    endcase
  end

  assign op_done  = (step_reg == op_words + 10'h001) && (osc_cnt_reg >= op_limit);
  assign step_idx = op_base + PROG_AW'(step_reg - 10'h001);

  always_comb begin
    case (state_reg)
      flash_access_pkg::ST_IDLE: begin
        if (tbl_rd || win_rd) begin
          state_next = flash_access_pkg::ST_RD1;
        end else if (op_start) begin
          state_next = flash_access_pkg::ST_OP;
        end else if (req) begin
          state_next = flash_access_pkg::ST_RESP;
        end else begin
          state_next = flash_access_pkg::ST_IDLE;
        end
      end
      flash_access_pkg::ST_RD1: state_next = flash_access_pkg::ST_RD2;
      flash_access_pkg::ST_RD2: begin
        state_next = (rd_win_reg && pen_reg != 2'd0) ? flash_access_pkg::ST_PEN
                     : flash_access_pkg::ST_RESP;
      end
      flash_access_pkg::ST_PEN: begin
        state_next = (pen_reg == 2'd1) ? flash_access_pkg::ST_RESP : flash_access_pkg::ST_PEN;
      end
      flash_access_pkg::ST_RESP: state_next = flash_access_pkg::ST_IDLE;
      flash_access_pkg::ST_OP: begin
        state_next = op_done ? flash_access_pkg::ST_RESP : flash_access_pkg::ST_OP;
      end
      default: state_next = flash_access_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_reg       <= flash_access_pkg::ST_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      state_reg       <= state_next;
      avs_waitrequest <= (state_next != flash_access_pkg::ST_RESP);
    end
  end

  // Any write other than the next key step closes the unlock sequence
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      key_reg <= flash_access_pkg::KEY_IDLE;
    end else if (req && avs_write) begin
      if (!is_win && avs_address == `OFS_UNLOCK_KEY && avs_byteenable[0]
          && avs_writedata[7:0] == `KEY_FIRST) begin
        key_reg <= flash_access_pkg::KEY_HALF;
      end else if (!is_win && avs_address == `OFS_UNLOCK_KEY && avs_byteenable[0]
                   && avs_writedata[7:0] == `KEY_SECOND
                   && key_reg == flash_access_pkg::KEY_HALF) begin
        key_reg <= flash_access_pkg::KEY_OPEN;
      end else begin
        key_reg <= flash_access_pkg::KEY_IDLE;
      end
    end
  end

  // Flash control: start bit is set-only, error flag set wins over clear
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wr_reg      <= 1'b0;
      wen_reg     <= 1'b0;
      err_reg     <= 1'b0;
      erase_reg   <= 1'b0;
      opsel_reg   <= 4'h0;
      op_kind_reg <= 4'h0;
    end else begin
      if (fc_wr) begin
        wen_reg   <= fc_new[`FC_WEN_BIT];
        erase_reg <= fc_new[`FC_ERASE_BIT];
        opsel_reg <= fc_new[3:0];
      end
      if (op_error) begin
        err_reg <= 1'b1;
      end else if (fc_wr && avs_byteenable[1] && !avs_writedata[`FC_ERR_BIT]) begin
        err_reg <= 1'b0;
      end
      if (op_start) begin
        wr_reg      <= 1'b1;
        op_kind_reg <= fc_new[3:0];
      end else if (state_reg == flash_access_pkg::ST_OP && op_done) begin
        wr_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      table_page_reg      <= 8'h00;
      visibility_page_reg <= 8'h00;
      core_control_reg    <= 16'h0000;
      table_addr_reg      <= 16'h0000;
      table_cmd_reg       <= 3'h0;
      window_timing_reg   <= 3'h0;
    end else if (req && avs_write && !is_win) begin
      case (avs_address)
        `OFS_TABLE_PAGE: begin
          if (avs_byteenable[0]) begin
            table_page_reg <= avs_writedata[7:0];
          end
        end
        `OFS_VIS_PAGE: begin
          if (avs_byteenable[0]) begin
            visibility_page_reg <= avs_writedata[7:0];
          end
        end
        `OFS_CORE_CONTROL: begin
          core_control_reg <= merge16(core_control_reg, avs_writedata[15:0], avs_byteenable[1:0]);
        end
        `OFS_TABLE_ADDR: begin
          table_addr_reg <= merge16(table_addr_reg, avs_writedata[15:0], avs_byteenable[1:0]);
        end
        `OFS_TABLE_CMD: begin
          if (avs_byteenable[0]) begin
            table_cmd_reg <= avs_writedata[2:0];
          end
        end
        `OFS_WINDOW_TIMING: begin
          if (avs_byteenable[0]) begin
            window_timing_reg <= avs_writedata[2:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Read address capture for table and window reads
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rd_idx_reg  <= '0;
      rd_cfg_reg  <= 1'b0;
      rd_win_reg  <= 1'b0;
      rd_high_reg <= 1'b0;
      rd_byte_reg <= 1'b0;
      rd_sel_reg  <= 1'b0;
      pen_reg     <= 2'd0;
    end else if (win_rd) begin
      rd_idx_reg <= PROG_AW'({visibility_page_reg, avs_address[14:1]});
      rd_cfg_reg <= 1'b0;
      rd_win_reg <= 1'b1;
      pen_reg    <= penalty;
    end else if (tbl_rd) begin
      rd_idx_reg  <= PROG_AW'(tbl_full[23:1]);
      rd_cfg_reg  <= table_page_reg[7];
      rd_win_reg  <= 1'b0;
      rd_high_reg <= avs_writedata[`TC_HIGH_BIT];
      rd_byte_reg <= avs_writedata[`TC_BYTE_BIT];
      rd_sel_reg  <= table_addr_reg[0];
    end else if (state_reg == flash_access_pkg::ST_PEN) begin
      pen_reg <= pen_reg - 2'd1;
    end
  end

  // Configuration space has no array here and reads a fixed word
  assign prog_word = rd_cfg_reg ? `CONFIG_READ_WORD : arr_rdata;

  always_comb begin
    if (rd_high_reg) begin
      if (rd_byte_reg && rd_sel_reg) begin
        tbl_result = 16'h0000;
      end else begin
        tbl_result = {8'h00, prog_word[23:16]};
      end
    end else if (rd_byte_reg) begin
      tbl_result = {8'h00, rd_sel_reg ? prog_word[15:8] : prog_word[7:0]};
    end else begin
      tbl_result = prog_word[15:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      table_data_reg <= 16'h0000;
    end else if (req && avs_write && !is_win && avs_address == `OFS_TABLE_DATA) begin
      table_data_reg <= merge16(table_data_reg, avs_writedata[15:0], avs_byteenable[1:0]);
    end else if (state_reg == flash_access_pkg::ST_RD2 && !rd_win_reg) begin
      table_data_reg <= tbl_result;
    end
  end

  always_comb begin
    case (avs_address)
      `OFS_FLASH_CONTROL: read_mux = fc_value;
      `OFS_TABLE_PAGE:    read_mux = {8'h00, table_page_reg};
      `OFS_VIS_PAGE:      read_mux = {8'h00, visibility_page_reg};
      `OFS_CORE_CONTROL:  read_mux = core_control_reg;
      `OFS_TABLE_ADDR:    read_mux = table_addr_reg;
      `OFS_TABLE_DATA:    read_mux = table_data_reg;
      `OFS_TABLE_CMD:     read_mux = {13'h0000, table_cmd_reg};
      `OFS_WINDOW_TIMING: read_mux = {13'h0000, window_timing_reg};
      default:            read_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      avs_readdata <= 32'h00000000;
    end else if (state_reg == flash_access_pkg::ST_RD2 && rd_win_reg) begin
      avs_readdata <= {16'h0000, arr_rdata[15:0]};
    end else if (req && avs_read) begin
      avs_readdata <= is_win ? 32'h00000000 : {16'h0000, read_mux};
    end
  end

  // Table writes land in the holding buffer only; the array waits for a start
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      buf_we_reg     <= 3'b000;
      buf_widx_reg   <= 6'h00;
      buf_wdata_reg  <= 24'h000000;
      target_idx_reg <= '0;
    end else begin
      buf_we_reg <= 3'b000;
      if (tbl_wr && !table_page_reg[7]) begin
        buf_widx_reg  <= tbl_full[6:1];
        buf_wdata_reg <= {table_data_reg[7:0], avs_writedata[`TC_BYTE_BIT]
                          ? {2{table_data_reg[7:0]}} : table_data_reg[15:0]};
        if (avs_writedata[`TC_HIGH_BIT]) begin
          buf_we_reg <= {!(avs_writedata[`TC_BYTE_BIT] && table_addr_reg[0]), 2'b00};
        end else begin
          buf_we_reg <= avs_writedata[`TC_BYTE_BIT]
                        ? {1'b0, table_addr_reg[0], !table_addr_reg[0]} : 3'b011;
          target_idx_reg <= PROG_AW'(tbl_full[23:1]);
        end
      end
    end
  end

  // Array updates run one word per cycle; done waits for both the last word and the fast RC count
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      step_reg    <= 10'h000;
      osc_cnt_reg <= 20'h00000;
    end else if (state_reg != flash_access_pkg::ST_OP) begin
      step_reg    <= 10'h000;
      osc_cnt_reg <= 20'h00000;
    end else begin
      if (step_reg != op_words + 10'h001) begin
        step_reg <= step_reg + 10'h001;
      end
      if (osc_tick && osc_cnt_reg < op_limit) begin
        osc_cnt_reg <= osc_cnt_reg + 20'h00001;
      end
    end
  end

  assign buf_raddr = (op_kind_reg == `OP_WORD) ? target_idx_reg[5:0] : step_reg[5:0];

  always_comb begin
    arr_we    = 3'b000;
    arr_waddr = step_idx;
    arr_wdata = buf_rdata;
    if (state_reg == flash_access_pkg::ST_OP && step_reg != 10'h000 && step_reg <= op_words) begin
      arr_we = 3'b111;
      if (op_kind_reg == `OP_PAGE) begin
        arr_wdata = `ERASED_WORD;
      end
    end
  end

  program_store #(
    .AW    (PROG_AW),
    .LANES (3)
  ) u_flash_array (
    .mclk    (mclk),
    .we_lane (arr_we),
    .waddr   (arr_waddr),
    .wdata   (arr_wdata),
    .raddr   (rd_idx_reg),
    .rdata   (arr_rdata)
  );

  program_store #(
    .AW    (6),
    .LANES (3)
  ) u_holding_buffer (
    .mclk    (mclk),
    .we_lane (buf_we_reg),
    .waddr   (buf_widx_reg),
    .wdata   (buf_wdata_reg),
    .raddr   (buf_raddr),
    .rdata   (buf_rdata)
  );

endmodule : program_space_access

`default_nettype wire

/* testbench/program_space_access_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module program_space_access_asserts (
  input wire logic        mclk,            // clock
  input wire logic        reset_n,         // reset
  input wire logic [15:0] avs_address,     // address
  input wire logic        avs_read,        // read
  input wire logic        avs_write,       // write
  input wire logic [31:0] avs_writedata,   // write data
  input wire logic [31:0] avs_readdata,    // read data
  input wire logic        avs_waitrequest  // stall
);
  logic [1:0] key_reg;
  logic [2:0] cmd_reg;
  logic       win_reg;
  logic       ea0_reg;
  wire        acc = avs_write && !avs_waitrequest;
  wire        rdy = avs_read && !avs_waitrequest;
  wire        st  = avs_write && avs_address == 16'h0000 && avs_writedata[15];
  wire        ok  = avs_writedata[6] ? avs_writedata[3:0] == 4'h2 : avs_writedata[3:0] inside {4'h1, 4'h3};
  wire        kw  = acc && avs_address == 16'h0004;
  // Any other accepted write closes the key, the start write included
  always_ff @(posedge mclk) begin
    if (!reset_n) key_reg <= 2'h0;
    else if (acc) key_reg <= (kw && avs_writedata[7:0] == 8'h55) ? 2'h1 :
                             (kw && key_reg == 2'h1 && avs_writedata[7:0] == 8'haa) ? 2'h2 : 2'h0;
  end
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cmd_reg <= 3'h0;
      win_reg <= 1'b0;
      ea0_reg <= 1'b0;
    end else if (acc) begin
      if (avs_address == 16'h001c) cmd_reg <= avs_writedata[2:0];
      if (avs_address == 16'h0010) win_reg <= avs_writedata[2];
      if (avs_address == 16'h0014) ea0_reg <= avs_writedata[0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  property p_win_off; rdy && avs_address[15] && !win_reg |-> avs_readdata == 32'h0; endproperty
  a_win_off: assert property (p_win_off) else $error("window read while disabled not zero");
  property p_win_len; $rose(avs_read) && avs_address[15] && win_reg |-> avs_waitrequest [*3]; endproperty
  a_win_len: assert property (p_win_len) else $error("window read without extra fetch");
  property p_nokey; $rose(avs_write) && st && key_reg != 2'h2 |-> ##[1:3] !avs_waitrequest; endproperty
  a_nokey: assert property (p_nokey) else $error("start without key stalled");
  property p_nowren; $rose(avs_write) && st && key_reg == 2'h2 && !avs_writedata[14] |-> ##[1:3] !avs_waitrequest;
  endproperty
  a_nowren: assert property (p_nowren) else $error("start without write enable stalled");
  property p_badop; $rose(avs_write) && st && key_reg == 2'h2 && avs_writedata[14] && !ok |-> ##[1:3] !avs_waitrequest;
  endproperty
  a_badop: assert property (p_badop) else $error("mismatched operation stalled");
  property p_stall; $rose(avs_write) && st && key_reg == 2'h2 && avs_writedata[14] && ok |-> avs_waitrequest [*8];
  endproperty
  a_stall: assert property (p_stall) else $error("started operation did not stall");
  property p_phantom; rdy && avs_address == 16'h0018 && cmd_reg == 3'h1 |-> avs_readdata[15:8] == 8'h00; endproperty
  a_phantom: assert property (p_phantom) else $error("high word read upper byte not zero");
  property p_hibyte; rdy && avs_address == 16'h0018 && cmd_reg == 3'h5 && ea0_reg |-> avs_readdata == 32'h0;
  endproperty
  a_hibyte: assert property (p_hibyte) else $error("high byte read of missing byte not zero");
endmodule : program_space_access_asserts
bind program_space_access program_space_access_asserts chk (.mclk(mclk), .reset_n(reset_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
`default_nettype wire

/* testbench/fast_rc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fast_rc_model (
  output logic osc_clock_in  // free-running oscillator
);
  // Period unrelated to the system clock so edges drift across it
  initial begin
    osc_clock_in = 1'b0;
    forever #68 osc_clock_in = ~osc_clock_in;
  end
endmodule : fast_rc_model
`default_nettype wire

/* testbench/test_program_space_access.sv */
`timescale 1ns/1ps
`default_nettype none
module test_program_space_access;
  logic        mclk, reset_n, avs_read, avs_write, avs_waitrequest, osc_clock_in;
  logic [15:0] avs_address, ea;
  logic [31:0] avs_writedata, avs_readdata, rdv;
  logic [23:0] pw;
  int          cyc, base, seed, error_cnt, n_tests;

  program_space_access #(.ROW_WRITE_OSC(40), .PAGE_ERASE_OSC(40), .WORD_WRITE_OSC(20)) uut (
    .mclk(mclk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .osc_clock_in(osc_clock_in));
  fast_rc_model osc (.osc_clock_in(osc_clock_in));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task results;
    $display("errors=%0d compares=%0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Holds the request until waitrequest is seen low; answer latency lands in cyc
  task bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    cyc = 0;
    do begin
      @(posedge mclk);
      cyc++;
    end while (avs_waitrequest !== 1'b0 && cyc < 5000);
    rdv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (cyc >= 5000) error_cnt++;
  endtask : bus

  task tcmd(input logic [15:0] a, input logic [2:0] c, input logic [15:0] d);
    bus(1'b1, 16'h0014, {16'h0, a});
    bus(1'b1, 16'h0018, {16'h0, d});
    bus(1'b1, 16'h001c, {29'h0, c});
    if (!c[1]) bus(1'b0, 16'h0018, 32'h0);
  endtask : tcmd

  // Key writes back to back with nothing between them
  task start(input logic [15:0] fc);
    bus(1'b1, 16'h0000, {16'h0, fc & 16'h7fff});
    bus(1'b1, 16'h0004, 32'h55);
    bus(1'b1, 16'h0004, 32'haa);
    bus(1'b1, 16'h0000, {16'h0, fc});
    bus(1'b0, 16'h0000, 32'h0);
  endtask : start

  function automatic int pen(input int t);
    return (t[1] && !t[2]) ? 0 : (t[0] && !t[2]) ? 1 : 2;
  endfunction : pen

  initial begin
    #2_000_000;
    error_cnt++;
    results();
  end

  initial begin
    seed = 34903;
    error_cnt = 0;
    n_tests = 0;
    reset_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    bus(1'b0, 16'h0000, 32'h0); chk(rdv, 32'h0);
    for (int i = 0; i < 64; i++) tcmd(16'(i * 2), 3'h2, 16'(i * 3));
    start(16'hc001); tcmd(16'h7e, 3'h0, 16'h0); chk(rdv, 32'hbd);
    repeat (2) begin
      ea = 16'($random(seed)) & 16'h3ffe;
      pw = 24'($random(seed));
      tcmd(ea, 3'h2, 16'h0);
      start(16'hc042); chk(rdv, 32'h4042);
      tcmd(ea, 3'h2, pw[15:0]);
      tcmd(ea, 3'h3, {8'h0, pw[23:16]});
      start(16'hc003); chk(rdv, 32'h4003);
      tcmd(ea, 3'h0, 16'h0); chk(rdv, {16'h0, pw[15:0]});
      tcmd(ea, 3'h1, 16'h0); chk(rdv, {24'h0, pw[23:16]});
      tcmd(ea, 3'h4, 16'h0); chk(rdv, {24'h0, pw[7:0]});
      tcmd(ea | 16'h1, 3'h4, 16'h0); chk(rdv, {24'h0, pw[15:8]});
      tcmd(ea | 16'h1, 3'h5, 16'h0); chk(rdv, 32'h0);
      tcmd(ea, 3'h5, 16'h0); chk(rdv, {24'h0, pw[23:16]});
      tcmd(ea ^ 16'h2, 3'h0, 16'h0); chk(rdv, 32'hffff);
    end
    bus(1'b0, 16'h8000 | ea, 32'h0); chk(rdv, 32'h0);
    bus(1'b1, 16'h0010, 32'h4);
    for (int t = 0; t < 8; t++) begin
      bus(1'b1, 16'h0020, 32'(t));
      bus(1'b0, 16'h8000 | ea, 32'h0); chk(rdv, {16'h0, pw[15:0]});
      if (t == 0) base = cyc - pen(t);
      chk(32'(cyc - pen(t)), 32'(base));
    end
    bus(1'b1, 16'h8000 | ea, 32'h1234);
    bus(1'b0, 16'h8000 | ea, 32'h0); chk(rdv, {16'h0, pw[15:0]});
    bus(1'b1, 16'h0008, 32'h80);
    tcmd(ea, 3'h0, 16'h0); chk(rdv, 32'hffff);
    bus(1'b1, 16'h0000, 32'h4003);
    bus(1'b1, 16'h0000, 32'hc003);
    bus(1'b0, 16'h0000, 32'h0); chk(rdv, 32'h6003);
    bus(1'b1, 16'h0000, 32'h4003);
    bus(1'b1, 16'h0004, 32'h55);
    bus(1'b1, 16'h0004, 32'haa);
    bus(1'b1, 16'h000c, 32'h0);
    bus(1'b1, 16'h0000, 32'hc003);
    bus(1'b0, 16'h0000, 32'h0); chk(rdv, 32'h6003);
    start(16'h8003); chk(rdv, 32'h2003);
    start(16'hc041); chk(rdv, 32'h4041);
    bus(1'b0, 16'h0004, 32'h0); chk(rdv, 32'h0);
    results();
  end
endmodule : test_program_space_access
`default_nettype wire
